// >>> design/ioc_pkg.sv
/*
  Constants, state enumeration and state record of the I/O device controller
  that sits on the processor I/O bus. Assumes a 250 MHz sys_clk.
*/
// How it works
// - Gated pulses skip, clear flag, load sum register, load external register.
// - Sum register is static; external register captures it only on a pulse.
// - Pulse with set flag asserts skip; otherwise skip stays low.
// - After its start command the device sends a halt pulse.
// - When finished the device sends a restart pulse to resume.
// - First transfer: request, direction and address appear together.
// - Inward data within 1 us after acceptance, held over 2 us.
// - Request dropped within 4 us ends the break, else another cycle.
// - Direction held until 4 us after acceptance; address may change.
// - Further transfers use a new address or increment request.
// - Increment request between 1 us and 4 us after acceptance.
package ioc_pkg;
  localparam int          CLK_NS      = 4;
  localparam int          EVT_NS      = 1000;
  localparam int          HOLD_MIN_NS = 2000;
  localparam int          INC_MIN_NS  = 1000;
  localparam int          INC_MAX_NS  = 4000;
  localparam int          DIR_HOLD_NS = 4000;
  localparam int          DW          = 12;
  localparam int          SW          = 6;
  // Strictly longer than the least hold time
  localparam logic [10:0] HOLD_CYC    = 11'(HOLD_MIN_NS / CLK_NS + 1);
  localparam logic [10:0] INC_LO_CYC  = 11'((INC_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] INC_HI_CYC  = 11'(INC_MAX_NS / CLK_NS);
  // Act two event times in, well inside the increment window
  localparam logic [10:0] ACT_CYC     = 11'((INC_MIN_NS + EVT_NS) / CLK_NS);
  localparam logic [10:0] DIR_CYC     = 11'((DIR_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0]  SEL_DEFAULT = 6'h0d;

  typedef enum logic [1:0]
  {
    IOC_IDLE = 2'b00,
    IOC_REQ  = 2'b01,
    IOC_XFER = 2'b10
  } ioc_brk_e;

  typedef struct packed
  {
    logic [DW-1:0] ext;
    logic          flag;
    logic          busy;
    logic          skip;
    logic [DW-1:0] ac_in;
    logic          halt;
    logic          restart;
    logic          start;
    ioc_brk_e      st;
    logic [10:0]   cnt;
    logic [DW-1:0] addr;
    logic [DW-1:0] left;
    logic          req;
    logic          outward;
    logic          inc;
    logic [DW-1:0] mbo;
    logic          mbo_en;
    logic [DW-1:0] rdata;
    logic          rvalid;
    logic          taken;
    logic          done;
  } ioc_state_s;

  localparam ioc_state_s STATE_RST = '0;
endpackage

// >>> design/ioc_dev_sel.sv
/*
  Device-select gate: passes timed I/O pulses for one wired device code.
  Assumes selection bits are stable while the pulses occur.
*/
`timescale 1ns/1ns
module ioc_dev_sel
#(
  parameter logic [5:0] SEL_CODE = ioc_pkg::SEL_DEFAULT
)
(
  input  wire logic [5:0] sel_bits,
  input  wire logic [2:0] timed_io_pulse,
  output logic      [2:0] iot_pulse
);
  // Pure gating keeps the pulses at their own event times
  assign iot_pulse = (sel_bits == SEL_CODE) ? timed_io_pulse : 3'h0;
endmodule

// >>> design/ioc_io_controller.sv
/*
  External device controller on the processor I/O bus: device-select gate,
  external register, flag with skip, halt/restart and a data break requester.
  Assumes all bus inputs are synchronous to sys_clk and pulses last one cycle.
*/
`timescale 1ns/1ns
module ioc_io_controller
#(
  parameter logic [5:0] SEL_CODE = ioc_pkg::SEL_DEFAULT
)
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [5:0]  sel_bits,
  input  wire logic [2:0]  timed_io_pulse,
  input  wire logic [11:0] sum_register,
  output logic      [11:0] sum_in_bus,
  output logic             io_skip_bus,
  output logic             io_halt_pulse,
  output logic             restart_pulse,
  output logic             break_request,
  output logic             break_outward,
  output logic      [11:0] break_address,
  output logic             increment_request,
  input  wire logic        address_accepted,
  input  wire logic [11:0] mb_data_in,
  output logic      [11:0] mb_data_out,
  output logic             mb_data_out_en,
  output logic      [11:0] dev_data_out,
  output logic             dev_start,
  input  wire logic        dev_done,
  input  wire logic [11:0] dev_result,
  output logic             dev_flag,
  input  wire logic        brk_go,
  input  wire logic        brk_outward,
  input  wire logic [11:0] brk_start_addr,
  input  wire logic [11:0] brk_words,
  input  wire logic [11:0] brk_wdata,
  output logic             brk_word_taken,
  output logic      [11:0] brk_rdata,
  output logic             brk_rvalid,
  output logic             brk_busy,
  output logic             brk_done
);
  ioc_pkg::ioc_state_s s_q;
  ioc_pkg::ioc_state_s s_d;
  logic [2:0]          iot;

  ioc_dev_sel #(.SEL_CODE(SEL_CODE)) u_sel
  (
    .sel_bits       (sel_bits),
    .timed_io_pulse (timed_io_pulse),
    .iot_pulse      (iot)
  );

  always_comb
  begin
    s_d         = s_q;
    s_d.skip    = iot[0] & s_q.flag;
    // All twelve bits in one cycle; the processor has cleared its register
    s_d.ac_in   = iot[1] ? s_q.ext : 12'h000;
    s_d.halt    = 1'b0;
    s_d.restart = 1'b0;
    s_d.start   = 1'b0;
    s_d.taken   = 1'b0;
    s_d.rvalid  = 1'b0;
    s_d.done    = 1'b0;
    if (iot[2])
    begin
      s_d.ext = sum_register;
      // A second start while busy only reloads the register; the halt is already standing
      if (!s_q.busy)
      begin
        s_d.start = 1'b1;
        s_d.halt  = 1'b1;
        s_d.busy  = 1'b1;
      end
    end
    if (s_q.busy && dev_done)
    begin
      s_d.busy    = 1'b0;
      s_d.restart = 1'b1;
      s_d.ext     = dev_result;
    end
    // Completion setting the flag wins over a clearing pulse
    s_d.flag = (s_q.flag & ~iot[1]) | (s_q.busy & dev_done);
    case (s_q.st)
      ioc_pkg::IOC_IDLE:
      begin
        if (brk_go && brk_words != 12'h000)
        begin
          s_d.st      = ioc_pkg::IOC_REQ;
          s_d.req     = 1'b1;
          s_d.outward = brk_outward;
          s_d.addr    = brk_start_addr;
          s_d.left    = brk_words - 12'h001;
        end
      end
      ioc_pkg::IOC_REQ:
      begin
        if (address_accepted)
        begin
          s_d.st  = ioc_pkg::IOC_XFER;
          s_d.cnt = 11'h000;
          s_d.inc = 1'b0;
          if (!s_q.outward)
          begin
            s_d.mbo    = brk_wdata;
            s_d.mbo_en = 1'b1;
            s_d.taken  = 1'b1;
          end
        end
      end
      ioc_pkg::IOC_XFER:
      begin
        s_d.cnt = s_q.cnt + 11'h001;
        if (s_q.cnt == ioc_pkg::HOLD_CYC)
        begin
          s_d.mbo_en = 1'b0;
        end
        if (s_q.cnt == ioc_pkg::ACT_CYC)
        begin
          if (s_q.left != 12'h000)
          begin
            s_d.inc = 1'b1;
          end
          else
          begin
            s_d.req = 1'b0;
          end
          if (s_q.outward)
          begin
            s_d.rdata  = mb_data_in;
            s_d.rvalid = 1'b1;
          end
        end
        // Direction may only move once this point is passed
        if (s_q.cnt == ioc_pkg::DIR_CYC)
        begin
          if (s_q.left != 12'h000)
          begin
            s_d.left = s_q.left - 12'h001;
            s_d.st   = ioc_pkg::IOC_REQ;
          end
          else
          begin
            s_d.st   = ioc_pkg::IOC_IDLE;
            s_d.done = 1'b1;
          end
        end
      end
      default:
      begin
        s_d.st = ioc_pkg::IOC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_q <= ioc_pkg::STATE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sum_in_bus        = s_q.ac_in;
  assign io_skip_bus       = s_q.skip;
  assign io_halt_pulse     = s_q.halt;
  assign restart_pulse     = s_q.restart;
  assign break_request     = s_q.req;
  assign break_outward     = s_q.outward;
  assign break_address     = s_q.addr;
  assign increment_request = s_q.inc;
  assign mb_data_out       = s_q.mbo;
  assign mb_data_out_en    = s_q.mbo_en;
  assign dev_data_out      = s_q.ext;
  assign dev_start         = s_q.start;
  assign dev_flag          = s_q.flag;
  assign brk_word_taken    = s_q.taken;
  assign brk_rdata         = s_q.rdata;
  assign brk_rvalid        = s_q.rvalid;
  assign brk_busy          = (s_q.st != ioc_pkg::IOC_IDLE);
  assign brk_done          = s_q.done;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_SKIP_SET: assert property (iot[0] && dev_flag |=> io_skip_bus)
    else $error("skip missing after strobe with flag set");
  AST_SKIP_QUIET: assert property (!(iot[0] && dev_flag) |=> !io_skip_bus)
    else $error("skip asserted without strobe and flag");
  AST_EXT_LOAD: assert property (iot[2] && !(s_q.busy && dev_done)
    |=> dev_data_out == $past(sum_register))
    else $error("external register missed sum register data");
  AST_EXT_STILL: assert property (!iot[2] && !(s_q.busy && dev_done)
    |=> $stable(dev_data_out))
    else $error("external register changed without strobe");
  AST_AC_IN: assert property (iot[1] |=> sum_in_bus == $past(dev_data_out))
    else $error("sum input bus not loaded from external register");
  AST_HALT: assert property (iot[2] && !s_q.busy
    |=> io_halt_pulse && dev_start ##1 !io_halt_pulse)
    else $error("halt pulse not sent after start");
  AST_RESTART: assert property (s_q.busy && dev_done
    |=> restart_pulse && dev_flag)
    else $error("restart pulse not sent on completion");
  AST_FIRST: assert property ($rose(break_request)
    |-> $past(brk_go) && break_address == $past(brk_start_addr)
        && break_outward == $past(brk_outward))
    else $error("request, direction and address not together");
  AST_DATA_HOLD: assert property (s_q.st == ioc_pkg::IOC_XFER && !break_outward
    && s_q.cnt <= ioc_pkg::HOLD_CYC |-> mb_data_out_en)
    else $error("inward data not held long enough");
  AST_DROP: assert property (address_accepted && s_q.st == ioc_pkg::IOC_REQ
    && s_q.left == 12'h000 |-> ##[1:1000] !break_request)
    else $error("break request not dropped in time");
  AST_DIR: assert property (s_q.st == ioc_pkg::IOC_XFER |=> $stable(break_outward))
    else $error("direction changed during break");
  AST_INC_WIN: assert property ($rose(increment_request)
    |-> s_q.cnt > ioc_pkg::INC_LO_CYC && s_q.cnt <= ioc_pkg::INC_HI_CYC)
    else $error("increment request outside its window");
  AST_INC_DUE: assert property (address_accepted && s_q.st == ioc_pkg::IOC_REQ
    && s_q.left != 12'h000 |-> ##[1:1000] increment_request)
    else $error("increment request missing for further word");

  COV_SKIP: cover property (iot[0] && dev_flag ##1 io_skip_bus);
  COV_HALT: cover property (io_halt_pulse ##[1:1000] restart_pulse);
  // The last word outlasts one range, so its own counter marks the end
  COV_MULTI: cover property (increment_request ##1 !increment_request
    ##[1:1000] (s_q.cnt == ioc_pkg::DIR_CYC && s_q.left == 12'h000)
    ##1 brk_done);
  COV_INWARD: cover property (brk_word_taken
    ##[1:1000] $fell(mb_data_out_en));
endmodule

// >>> testbench/ioc_proc_model.sv
/*
  Behavioural processor side of the I/O bus: timed pulses, static sum
  register, skip and halt latches, and data break memory cycles.
  Assumes the controller under test answers on the rising edge of sys_clk.
*/
`timescale 1ns/1ns
module ioc_proc_model
#(
  parameter int EVT = 250,
  parameter int LAG = 40
)
(
  input  wire logic        sys_clk,
  output logic      [5:0]  sel_bits,
  output logic      [2:0]  timed_io_pulse,
  output logic      [11:0] sum_register,
  output logic             address_accepted,
  output logic      [11:0] mb_data_in,
  input  wire logic [11:0] sum_in_bus,
  input  wire logic        io_skip_bus,
  input  wire logic        io_halt_pulse,
  input  wire logic        restart_pulse,
  input  wire logic        break_request,
  input  wire logic        break_outward,
  input  wire logic [11:0] break_address,
  input  wire logic        increment_request,
  input  wire logic [11:0] mb_data_out,
  input  wire logic        mb_data_out_en,
  input  wire logic        intr_request
);
  logic [11:0] mem [0:4095];
  logic [11:0] ac;
  logic [11:0] mar;
  logic        skipped;
  logic        halted;
  logic        again;
  int          accepts;
  logic [11:0] pc;
  logic        int_en;
  logic        int_arm;
  logic        jumped;

  localparam logic [11:0] INT_ON_CODE  = 12'hc01;
  localparam logic [11:0] INT_OFF_CODE = 12'hc02;

  assign sum_register = ac;

  always @(posedge sys_clk)
  begin
    if (sum_in_bus !== 12'h000)
      ac <= ac | sum_in_bus;
    if (io_skip_bus === 1'b1)
      skipped <= 1'b1;
    if (io_halt_pulse === 1'b1)
      halted <= 1'b1;
    else if (restart_pulse === 1'b1)
      halted <= 1'b0;
  end

  // Bit 0 of ins is instruction bit 11, so it fires first
  task automatic iot(input logic [8:0] ins);
    @(posedge sys_clk);
    sel_bits <= ins[8:3];
    skipped <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      repeat (EVT - 1) @(posedge sys_clk);
      timed_io_pulse[i] <= ins[i];
      @(posedge sys_clk);
      timed_io_pulse <= 3'h0;
    end
    repeat (EVT) @(posedge sys_clk);
  endtask

  // Interrupts are looked at only once an instruction has run to its end
  task automatic step(input logic [11:0] code);
    repeat (LAG) @(posedge sys_clk);
    pc = pc + 12'h001;
    if (int_arm)
    begin
      int_en = 1'b1;
      int_arm = 1'b0;
    end
    if (code == INT_ON_CODE)
      int_arm = 1'b1;
    else if (code == INT_OFF_CODE)
    begin
      int_en = 1'b0;
      int_arm = 1'b0;
    end
    // A request seen while disabled simply waits on its level
    if (int_en && intr_request === 1'b1)
    begin
      mem[1] = pc;
      pc = 12'h002;
      int_en = 1'b0;
    end
  endtask

  // Break cycles touch only mar, mem and, after a jump, pc; never ac
  initial
  begin
    sel_bits = 6'h00;
    timed_io_pulse = 3'h0;
    ac = 12'h000;
    skipped = 1'b0;
    halted = 1'b0;
    accepts = 0;
    pc = 12'h000;
    int_en = 1'b0;
    int_arm = 1'b0;
    jumped = 1'b0;
    address_accepted = 1'b0;
    mb_data_in = 12'hfff;
    forever
    begin
      @(posedge sys_clk);
      if (break_request === 1'b1)
      begin
        repeat (LAG) @(posedge sys_clk);
        // After a jump or call the following instruction runs first
        if (jumped)
        begin
          repeat (LAG) @(posedge sys_clk);
          pc = pc + 12'h001;
          jumped = 1'b0;
        end
        mar = break_address;
        again = 1'b1;
        while (again)
        begin
          address_accepted <= 1'b1;
          mb_data_in <= mem[mar];
          @(posedge sys_clk);
          address_accepted <= 1'b0;
          accepts++;
          repeat (2 * EVT - 1) @(posedge sys_clk);
          if (!break_outward && mb_data_out_en === 1'b1)
            mem[mar] = mb_data_out;
          repeat (2 * EVT) @(posedge sys_clk);
          // Inverted data so a late sample cannot match by chance
          mb_data_in <= ~mem[mar];
          again = (break_request === 1'b1);
          if (increment_request === 1'b1)
            mar = mar + 12'h001;
          repeat (2 * EVT) @(posedge sys_clk);
        end
      end
    end
  end
endmodule

// >>> testbench/tb_io_control_element.sv
/*
  Self-checking bench for the I/O device controller.
  Assumes the processor model stands on the bus side of the controller.
*/
`timescale 1ns/1ns
module tb_io_control_element;
  logic        sys_clk, reset, io_skip_bus, io_halt_pulse, restart_pulse;
  logic        break_request, break_outward, increment_request, dev_flag;
  logic        address_accepted, mb_data_out_en, dev_start, dev_done;
  logic        brk_go, brk_outward, brk_word_taken, brk_rvalid;
  logic        brk_busy, brk_done;
  logic [5:0]  sel_bits;
  logic [2:0]  timed_io_pulse;
  logic [11:0] sum_register, sum_in_bus, break_address, mb_data_in, rd;
  logic [11:0] mb_data_out, dev_data_out, dev_result, brk_start_addr;
  logic [11:0] brk_words, brk_wdata, brk_rdata;
  int          fails;
  int          compares;
  int          acc0;
  int          takens;
  logic [11:0] pc0;

  ioc_io_controller u_ioc_io_controller
  (
    .sys_clk, .reset, .sel_bits, .timed_io_pulse, .sum_register,
    .sum_in_bus, .io_skip_bus, .io_halt_pulse, .restart_pulse,
    .break_request, .break_outward, .break_address, .increment_request,
    .address_accepted, .mb_data_in, .mb_data_out, .mb_data_out_en,
    .dev_data_out, .dev_start, .dev_done, .dev_result, .dev_flag, .brk_go,
    .brk_outward, .brk_start_addr, .brk_words, .brk_wdata, .brk_word_taken,
    .brk_rdata, .brk_rvalid, .brk_busy, .brk_done
  );

  ioc_proc_model u_ioc_proc_model
  (
    .sys_clk, .sel_bits, .timed_io_pulse, .sum_register, .address_accepted,
    .mb_data_in, .sum_in_bus, .io_skip_bus, .io_halt_pulse, .restart_pulse,
    .break_request, .break_outward, .break_address, .increment_request,
    .mb_data_out, .mb_data_out_en,
    .intr_request (dev_flag)
  );

  task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                     input string m);
    compares++;
    if (got !== exp)
    begin
      $display("[ERR] %0t %s", $time, m);
      fails++;
    end
  endtask

  task automatic final_report();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic brk_run(input logic o, input logic [11:0] a,
                         input logic [11:0] n, input logic [11:0] w);
    int i;
    acc0 = u_ioc_proc_model.accepts;
    takens = 0;
    @(posedge sys_clk);
    brk_go <= 1'b1;
    brk_outward <= o;
    brk_start_addr <= a;
    brk_words <= n;
    brk_wdata <= w;
    @(posedge sys_clk);
    brk_go <= 1'b0;
    for (i = 0; i < 4000; i++)
    begin
      @(posedge sys_clk);
      if (brk_rvalid === 1'b1)
        rd = brk_rdata;
      if (brk_word_taken === 1'b1)
        takens++;
      if (brk_done === 1'b1)
        break;
    end
    if (i == 4000)
    begin
      chk(12'h001, 12'h000, "break never finished");
      final_report();
    end
  endtask

  task automatic t_select();
    @(posedge sys_clk);
    u_ioc_proc_model.ac <= 12'h5a3;
    u_ioc_proc_model.iot({6'h0c, 3'b111});
    chk(u_ioc_proc_model.skipped, 12'h000, "foreign skip");
    chk(u_ioc_proc_model.halted, 12'h000, "foreign halt");
    chk(dev_data_out, 12'h000, "foreign load");
  endtask

  task automatic t_load_start();
    u_ioc_proc_model.iot({6'h0d, 3'b100});
    chk(dev_data_out, 12'h5a3, "register not loaded");
    chk(u_ioc_proc_model.halted, 12'h001, "no halt");
    @(posedge sys_clk);
    dev_done <= 1'b1;
    dev_result <= 12'h3c6;
    @(posedge sys_clk);
    dev_done <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(u_ioc_proc_model.halted, 12'h000, "no restart");
    chk(dev_flag, 12'h001, "flag not set");
  endtask

  task automatic t_skip_read();
    @(posedge sys_clk);
    u_ioc_proc_model.ac <= 12'h000;
    u_ioc_proc_model.iot({6'h0d, 3'b011});
    chk(u_ioc_proc_model.skipped, 12'h001, "no skip");
    chk(u_ioc_proc_model.ac, 12'h3c6, "read wrong");
    chk(dev_flag, 12'h000, "flag kept");
    u_ioc_proc_model.iot({6'h0d, 3'b001});
    chk(u_ioc_proc_model.skipped, 12'h000, "skip on clear flag");
  endtask

  task automatic t_break_in();
    for (int k = 256; k < 259; k++)
      u_ioc_proc_model.mem[k] = 12'h000;
    pc0 = u_ioc_proc_model.pc;
    u_ioc_proc_model.jumped = 1'b1;
    brk_run(1'b0, 12'h100, 12'h002, 12'h4e7);
    chk(12'(u_ioc_proc_model.accepts - acc0), 12'h002, "cycles");
    chk(u_ioc_proc_model.mem[256], 12'h4e7, "first word");
    chk(u_ioc_proc_model.mem[257], 12'h4e7, "next word");
    chk(u_ioc_proc_model.mem[258], 12'h000, "extra word");
    chk(12'(takens), 12'h002, "inward words taken");
    chk(u_ioc_proc_model.pc, pc0 + 12'h001, "no extra instruction");
  endtask

  task automatic t_break_out();
    u_ioc_proc_model.mem[512] = 12'h6b9;
    rd = 12'h000;
    brk_run(1'b1, 12'h200, 12'h001, 12'h000);
    chk(rd, 12'h6b9, "outward word");
    chk(12'(u_ioc_proc_model.accepts - acc0), 12'h001, "cycles");
    chk(u_ioc_proc_model.ac, 12'h3c6, "sum register moved");
    chk(u_ioc_proc_model.pc, pc0 + 12'h001, "counter moved");
    chk(brk_busy, 12'h000, "break still busy");
  endtask

  task automatic t_interrupt();
    u_ioc_proc_model.iot({6'h0d, 3'b100});
    @(posedge sys_clk);
    dev_done <= 1'b1;
    @(posedge sys_clk);
    dev_done <= 1'b0;
    u_ioc_proc_model.pc = 12'h050;
    u_ioc_proc_model.step(12'h000);
    chk(u_ioc_proc_model.pc, 12'h051, "taken while off");
    u_ioc_proc_model.step(u_ioc_proc_model.INT_ON_CODE);
    chk(u_ioc_proc_model.pc, 12'h052, "enabled at once");
    u_ioc_proc_model.step(12'h000);
    chk(u_ioc_proc_model.mem[1], 12'h053, "saved counter");
    chk(u_ioc_proc_model.pc, 12'h002, "no call to 1");
    chk(u_ioc_proc_model.int_en, 12'h000, "enable kept");
    u_ioc_proc_model.step(u_ioc_proc_model.INT_ON_CODE);
    u_ioc_proc_model.step(u_ioc_proc_model.INT_OFF_CODE);
    chk(u_ioc_proc_model.pc, 12'h004, "response not disabled");
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial
  begin
    fails = 0;
    compares = 0;
    reset = 1'b1;
    {dev_done, brk_go, brk_outward} = 3'h0;
    {dev_result, brk_start_addr, brk_words, brk_wdata} = 48'h0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_select();
    t_load_start();
    t_skip_read();
    t_break_in();
    t_break_out();
    t_interrupt();
    final_report();
  end
endmodule
